/* File: logic/trig_detector.sv */
// How it works
// [RULE_01] Start from software, external, ADC level, log level, immediate.
// [RULE_02] Rising or falling slope for external and ADC level sources.
// [RULE_03] ADC level trigger uses a 20 count hysteresis band.
// [RULE_04] Log level trigger uses a 1.5 dB hysteresis band.
// [RULE_05] Log level comes from filtered complex data; upward crossings only.
// [RULE_06] External input selectable between ECL and TTL signalling.
// [RULE_07] In ECL mode an initial pulse must precede real triggers.
// [RULE_08] Source is sampled once per sample clock enable.
// [RULE_09] Shared sync line lets every module trigger on one sample.
// [RULE_10] Block mode stops once the programmed block is captured.
// [RULE_11] Continuous mode stops only on buffer overflow.
// [RULE_12] Complex data counts block length in real-imaginary pairs.
// [RULE_13] Signed offset gives pre- or post-trigger shift.
// [RULE_14] After acceptance further triggers are ignored until re-armed.
// [RULE_15] Immediate and software sources fire on the next sample.
`include "trig_params.svh"
`default_nettype none
module trig_detector
  import trig_pkg::*;
#(
  parameter int ADC_W = `TRIG_ADC_W,
  parameter int LM_W = `TRIG_LM_W,
  parameter int LEN_W = `TRIG_LEN_W,
  parameter int OFS_W = `TRIG_OFS_W
)(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Sample stream
  input wire logic i_sample_en,
  input wire logic signed [ADC_W-1:0] i_adc_sample,
  input wire logic signed [LM_W-1:0] i_logmag,
  // Pins
  input wire logic i_ext_trig_pin,
  input wire logic i_sync_pin,
  output logic o_sync_out,
  output logic o_sync_oe,
  // Configuration
  input wire logic [2:0] i_src,
  input wire logic i_slope_fall,
  input wire logic i_ext_ecl,
  input wire logic signed [ADC_W-1:0] i_adc_level,
  input wire logic signed [LM_W-1:0] i_logmag_level,
  input wire logic i_sync_drive,
  input wire logic i_sync_follow,
  input wire logic i_continuous,
  input wire logic i_complex,
  input wire logic [LEN_W-1:0] i_block_len,
  input wire logic signed [OFS_W-1:0] i_trig_offset,
  // Control
  input wire logic i_arm,
  input wire logic i_sw_trig,
  input wire logic i_buf_overflow,
  // Status
  output logic o_armed,
  output logic o_triggered,
  output logic o_capture,
  output logic o_done,
  output logic o_overflow_stop,
  output logic o_ext_ready,
  output logic [OFS_W-1:0] o_pre_len
);

  if (ADC_W < 8 || LM_W < 8 || LEN_W < 2 || OFS_W < 2) begin : g_bad
    $error("trig_detector: width parameter too small");
  end

  trig_state_t state_reg;
  trig_src_t src;
  logic [1:0] ext_sync_reg;
  logic [1:0] sync_sync_reg;
  logic ext_prev_reg;
  logic ecl_ready_reg;
  logic sw_pend_reg;
  logic sync_oe_reg;
  logic half_reg;
  logic ovf_reg;
  logic [LEN_W-1:0] cnt_reg;
  logic [OFS_W-1:0] dly_reg;
  logic [OFS_W-1:0] pre_reg;
  logic ext_hit;
  logic local_hit;
  logic sync_low;
  logic accept;
  logic tick;
  logic stop;

  assign src = trig_src_t'(i_src);

  trig_lvl_if #(.W(ADC_W)) adc_if ();
  trig_lvl_if #(.W(LM_W)) lm_if ();

  // ----------------------------------------
  // Level detectors
  // ----------------------------------------
  assign adc_if.sample = i_adc_sample;
  assign adc_if.level = i_adc_level;
  // [RULE_03] ADC band width
  assign adc_if.hyst = ADC_W'(`TRIG_ADC_HYST);
  assign adc_if.fall = i_slope_fall;
  // [RULE_08] evaluated per sample
  assign adc_if.en = i_sample_en;
  assign adc_if.clr = i_arm;

  assign lm_if.sample = i_logmag;
  assign lm_if.level = i_logmag_level;
  // [RULE_04] 1.5 dB band
  assign lm_if.hyst = LM_W'(`TRIG_LM_HYST);
  // [RULE_05] upward only
  assign lm_if.fall = 1'b0;
  assign lm_if.en = i_sample_en;
  assign lm_if.clr = i_arm;

  trig_level_det #(.W(ADC_W)) u_adc_det (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .lvl(adc_if.det)
  );

  trig_level_det #(.W(LM_W)) u_lm_det (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .lvl(lm_if.det)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_sync_reg <= 2'h0;
      sync_sync_reg <= 2'h3;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], i_ext_trig_pin};
      sync_sync_reg <= {sync_sync_reg[0], i_sync_pin};
    end
  end

  // ----------------------------------------
  // External trigger
  // ----------------------------------------
  // [RULE_07] ECL path primed by first edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_prev_reg <= 1'b0;
      ecl_ready_reg <= 1'b0;
    end else if (i_sample_en) begin
      ext_prev_reg <= ext_sync_reg[1];
      if (ext_sync_reg[1] != ext_prev_reg) begin
        ecl_ready_reg <= 1'b1;
      end
    end
  end

  // [RULE_06] ECL needs priming, TTL not
  assign ext_hit = (!i_ext_ecl || ecl_ready_reg) &&
                   (i_slope_fall ? (ext_prev_reg && !ext_sync_reg[1])
                                 : (!ext_prev_reg && ext_sync_reg[1]));
  assign o_ext_ready = ecl_ready_reg;

  // ----------------------------------------
  // Software command
  // ----------------------------------------
  // [RULE_15] held until next sample, set wins
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sw_pend_reg <= 1'b0;
    end else if (i_sw_trig) begin
      sw_pend_reg <= 1'b1;
    end else if (i_sample_en) begin
      sw_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Source select
  // ----------------------------------------
  // [RULE_01] five sources
  always_comb begin
    local_hit = 1'b0;
    if (state_reg == ST_ARMED && i_sample_en) begin
      unique case (src)
        SRC_SW: local_hit = sw_pend_reg;
        SRC_EXT: local_hit = ext_hit;
        SRC_ADC: local_hit = adc_if.hit;
        SRC_LOGMAG: local_hit = lm_if.hit;
        SRC_IMM: local_hit = 1'b1;
        default: local_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Shared sync line
  // ----------------------------------------
  // [RULE_09] drive low until trigger accepted
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync_oe_reg <= 1'b0;
    end else if (state_reg != ST_ARMED || i_arm) begin
      sync_oe_reg <= 1'b0;
    end else if (local_hit && i_sync_drive) begin
      sync_oe_reg <= 1'b1;
    end
  end

  assign o_sync_out = 1'b0;
  assign o_sync_oe = sync_oe_reg;
  assign sync_low = !sync_sync_reg[1];

  // [RULE_09] follow the line for common sample
  // [RULE_14] only while armed
  assign accept = state_reg == ST_ARMED && i_sample_en && !i_arm &&
                  (i_sync_follow ? sync_low : local_hit);

  // ----------------------------------------
  // Measurement sequence
  // ----------------------------------------
  // [RULE_12] pairs counted on imaginary word
  assign tick = state_reg == ST_CAPTURE && i_sample_en &&
                (!i_complex || half_reg);
  // [RULE_10] block end, [RULE_11] overflow end
  assign stop = i_continuous ? i_buf_overflow
                             : (tick && cnt_reg == i_block_len - 1'b1);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
    end else if (i_arm) begin
      state_reg <= ST_ARMED;
    end else begin
      unique case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_ARMED: begin
          if (accept) begin
            state_reg <= (i_trig_offset > 0) ? ST_DELAY : ST_CAPTURE;
          end
        end
        ST_DELAY: begin
          if (i_sample_en && dly_reg == OFS_W'(1)) begin
            state_reg <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: begin
          if (stop) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // [RULE_13] post delay and pre length
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dly_reg <= '0;
      pre_reg <= '0;
    end else if (accept) begin
      dly_reg <= (i_trig_offset > 0) ? $unsigned(i_trig_offset) : '0;
      pre_reg <= (i_trig_offset < 0) ? $unsigned(-i_trig_offset) : '0;
    end else if (state_reg == ST_DELAY && i_sample_en) begin
      dly_reg <= dly_reg - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
      half_reg <= 1'b0;
    end else if (i_arm) begin
      cnt_reg <= '0;
      half_reg <= 1'b0;
    end else if (state_reg == ST_CAPTURE && i_sample_en) begin
      half_reg <= i_complex && !half_reg;
      if (tick) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovf_reg <= 1'b0;
    end else if (i_arm) begin
      ovf_reg <= 1'b0;
    end else if (state_reg == ST_CAPTURE && i_continuous && stop) begin
      ovf_reg <= 1'b1;
    end
  end

  assign o_armed = state_reg == ST_ARMED;
  assign o_triggered = state_reg == ST_DELAY || state_reg == ST_CAPTURE ||
                       state_reg == ST_DONE;
  assign o_capture = state_reg == ST_CAPTURE && i_sample_en;
  assign o_done = state_reg == ST_DONE;
  assign o_overflow_stop = ovf_reg;
  assign o_pre_len = pre_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_stopped;
    !o_capture && o_done;
  endsequence

  property p_imm;
    o_armed && src == SRC_IMM && i_sample_en && !i_sync_follow && !i_arm
      |=> o_triggered;
  endproperty
  a_imm: assert property (p_imm) // [RULE_15]
    else $error("immediate source did not fire on first sample");

  property p_sw;
    o_armed && src == SRC_SW && sw_pend_reg && i_sample_en &&
      !i_sync_follow && !i_arm |=> o_triggered;
  endproperty
  a_sw: assert property (p_sw) // [RULE_15]
    else $error("software command not taken on next sample");

  property p_hold;
    o_triggered && !i_arm |=> o_triggered && !o_armed;
  endproperty
  a_hold: assert property (p_hold) // [RULE_14]
    else $error("trigger state left without re-arm");

  property p_on_sample;
    o_armed && !i_arm && !i_sample_en |=> o_armed;
  endproperty
  a_on_sample: assert property (p_on_sample) // [RULE_08]
    else $error("trigger taken without sample enable");

  property p_block;
    !i_continuous && tick && cnt_reg == i_block_len - 1'b1 && !i_arm
      |=> s_stopped;
  endproperty
  a_block: assert property (p_block) // [RULE_10]
    else $error("block capture did not stop at block length");

  property p_cont;
    i_continuous && state_reg == ST_CAPTURE && i_buf_overflow && !i_arm
      |=> s_stopped ##0 o_overflow_stop;
  endproperty
  a_cont: assert property (p_cont) // [RULE_11]
    else $error("continuous capture did not stop on overflow");

  property p_no_early_stop;
    i_continuous && state_reg == ST_CAPTURE && !i_buf_overflow && !i_arm
      |=> state_reg == ST_CAPTURE;
  endproperty
  a_no_early_stop: assert property (p_no_early_stop) // [RULE_11]
    else $error("continuous capture stopped without overflow");

  property p_pair;
    i_complex && tick |=> !tick;
  endproperty
  a_pair: assert property (p_pair) // [RULE_12]
    else $error("complex pair counted twice");

  property p_sync;
    local_hit && i_sync_drive && !i_arm |=> o_sync_oe;
  endproperty
  a_sync: assert property (p_sync) // [RULE_09]
    else $error("sync line not driven after local trigger");

  property p_pre;
    accept && i_trig_offset < 0
      |=> o_pre_len == $unsigned(-$past(i_trig_offset));
  endproperty
  a_pre: assert property (p_pre) // [RULE_13]
    else $error("pre-trigger length not latched");

endmodule
`default_nettype wire

/* File: logic/trig_level_det.sv */
`default_nettype none
module trig_level_det #(
  parameter int W = 12
)(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Level channel
  trig_lvl_if.det lvl
);

  logic armed_reg;
  logic signed [W:0] s_ext;
  logic signed [W:0] lv_ext;
  logic signed [W:0] hy_ext;
  logic signed [W:0] lo;
  logic signed [W:0] hi;

  assign s_ext = {lvl.sample[W-1], lvl.sample};
  assign lv_ext = {lvl.level[W-1], lvl.level};
  assign hy_ext = $signed({1'b0, lvl.hyst});
  assign lo = lv_ext - hy_ext;
  assign hi = lv_ext + hy_ext;

  // ----------------------------------------
  // Hysteresis arming
  // ----------------------------------------
  // [RULE_03] band must be left first
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      armed_reg <= 1'b0;
    end else if (lvl.clr) begin
      armed_reg <= 1'b0;
    end else if (lvl.en) begin
      if (lvl.hit) begin
        armed_reg <= 1'b0;
      end else if (lvl.fall ? (s_ext > hi) : (s_ext < lo)) begin
        armed_reg <= 1'b1;
      end
    end
  end

  // [RULE_02] slope chooses crossing
  assign lvl.hit = lvl.en && armed_reg &&
                   (lvl.fall ? (s_ext <= lv_ext) : (s_ext >= lv_ext));

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_one_shot;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      lvl.hit |=> !lvl.hit;
  endproperty
  a_one_shot: assert property (p_one_shot) // [RULE_03]
    else $error("level hit repeated without leaving band");

endmodule
`default_nettype wire

/* File: logic/trig_lvl_if.sv */
`default_nettype none
interface trig_lvl_if #(
  parameter int W = 12
);
  logic signed [W-1:0] sample;
  logic signed [W-1:0] level;
  logic [W-1:0] hyst;
  logic fall;
  logic en;
  logic clr;
  logic hit;

  modport src (
    output sample, level, hyst, fall, en, clr,
    input hit
  );
  modport det (
    input sample, level, hyst, fall, en, clr,
    output hit
  );
endinterface
`default_nettype wire

/* File: logic/trig_params.svh */
`ifndef TRIG_PARAMS_SVH
`define TRIG_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TRIG_ADC_W 12
`define TRIG_LM_W 16
`define TRIG_LEN_W 24
`define TRIG_OFS_W 16

// ----------------------------------------
// Hysteresis bands
// ----------------------------------------
// ADC counts
`define TRIG_ADC_HYST 20
// Log magnitude in tenths of a dB
`define TRIG_LM_HYST 15

// ----------------------------------------
// Select codes
// ----------------------------------------
`define TRIG_SRC_SW 3'h0
`define TRIG_SRC_EXT 3'h1
`define TRIG_SRC_ADC 3'h2
`define TRIG_SRC_LOGMAG 3'h3
`define TRIG_SRC_IMM 3'h4

`endif

/* File: logic/trig_pkg.sv */
`include "trig_params.svh"
`default_nettype none
package trig_pkg;

  typedef enum logic [2:0] {
    SRC_SW = `TRIG_SRC_SW,
    SRC_EXT = `TRIG_SRC_EXT,
    SRC_ADC = `TRIG_SRC_ADC,
    SRC_LOGMAG = `TRIG_SRC_LOGMAG,
    SRC_IMM = `TRIG_SRC_IMM
  } trig_src_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_DELAY,
    ST_CAPTURE,
    ST_DONE
  } trig_state_t;

endpackage
`default_nettype wire

/* File: sim/sync_partner.sv */
`default_nettype none
module sync_partner (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Group trigger request and line pull
  input wire logic i_fire,
  output logic o_sync_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] hold_reg;
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_reg <= 3'h0;
    end else if (i_fire) begin
      hold_reg <= 3'h6;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end
  assign o_sync_oe = (hold_reg != 3'h0);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`include "trig_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn, sen, ext, sw, arm, ovf, fall, ecl, drv, fol, cont, cplx;
  logic fire;
  logic [2:0] src;
  logic signed [11:0] adc, alvl;
  logic signed [15:0] lm, llvl, ofs;
  logic [23:0] blen;
  logic sync_oe, sync_out, p_oe, armed, trig, cap, done, ostop, xrdy;
  logic [15:0] pre;
  wire logic sync_line;
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 48;
  int cnt;
  int lv[3][5] = '{'{150, 90, 150, 70, 150}, '{50, 110, 50, 130, 50},
    '{30, -10, 30, -20, 30}};

  assign sync_line = !(sync_oe | p_oe);

  trig_detector trig_detector_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_sample_en(sen),
    .i_adc_sample(adc), .i_logmag(lm), .i_ext_trig_pin(ext),
    .i_sync_pin(sync_line), .o_sync_out(sync_out), .o_sync_oe(sync_oe),
    .i_src(src), .i_slope_fall(fall), .i_ext_ecl(ecl),
    .i_adc_level(alvl), .i_logmag_level(llvl), .i_sync_drive(drv),
    .i_sync_follow(fol), .i_continuous(cont), .i_complex(cplx),
    .i_block_len(blen), .i_trig_offset(ofs), .i_arm(arm),
    .i_sw_trig(sw), .i_buf_overflow(ovf), .o_armed(armed),
    .o_triggered(trig), .o_capture(cap), .o_done(done),
    .o_overflow_stop(ostop), .o_ext_ready(xrdy), .o_pre_len(pre)
  );

  sync_partner sync_partner_i (
    .i_ref_clk(clk), .i_rstn(rstn), .i_fire(fire), .o_sync_oe(p_oe)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int caps_exp(input int len, input logic c);
    return c ? 2 * len : len;
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Sample pulses, counting stored samples
  task automatic samp(input int n);
    repeat (n) begin
      sen = 1'b1;
      #4 cnt += int'(cap === 1'b1);
      tick();
      sen = 1'b0;
      tick();
    end
  endtask

  task automatic do_arm(input logic [2:0] s);
    src = s;
    arm = 1'b1;
    tick();
    arm = 1'b0;
    cnt = 0;
    tick();
    chk(armed, 1'b1);
  endtask

  task automatic edge_to(input logic v);
    ext = v;
    tick();
    tick();
    samp(1);
  endtask

  task automatic run_block(input int len, input logic c);
    int i;
    blen = 24'(len);
    cplx = c;
    do_arm(`TRIG_SRC_IMM);
    samp(1);
    chk(trig, 1'b1);
    i = 0;
    while (done !== 1'b1 && i < 20) begin
      samp(1);
      i++;
    end
    samp(2);
    chk(24'(cnt), 24'(caps_exp(len, c)));
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int i, j, k, r;
    {rstn, sen, ext, sw, arm, ovf, fall, ecl, drv, fol, cont} = '0;
    {cplx, fire} = '0;
    src = 3'h7;
    adc = '0;
    lm = '0;
    alvl = 12'sh064;
    llvl = 16'sh0;
    ofs = '0;
    blen = 24'h1;
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    tick();
    chk({armed, trig, done, ostop, xrdy, sync_oe, sync_out}, 7'h0);
    ecl = 1'b1;
    do_arm(`TRIG_SRC_EXT);
    // Priming pulse before use
    edge_to(1'b1);
    chk({trig, xrdy}, 2'b01);
    edge_to(1'b0);
    chk(trig, 1'b0);
    edge_to(1'b1);
    chk(trig, 1'b1);
    ecl = 1'b0;
    fall = 1'b1;
    do_arm(`TRIG_SRC_EXT);
    samp(1);
    chk(trig, 1'b0);
    edge_to(1'b0);
    chk(trig, 1'b1);
    for (k = 0; k < 3; k++) begin
      fall = (k == 1);
      do_arm(k == 2 ? `TRIG_SRC_LOGMAG : `TRIG_SRC_ADC);
      repeat (4) begin
        r = $random(seed) % 15;
        adc = 12'(100 + r);
        lm = 16'(r);
        samp(1);
        chk(trig, 1'b0);
      end
      for (j = 0; j < 5; j++) begin
        adc = 12'(lv[k][j]);
        lm = 16'(lv[k][j]);
        samp(1);
        chk(trig, 1'(j == 4));
      end
    end
    do_arm(`TRIG_SRC_SW);
    sw = 1'b1;
    tick();
    sw = 1'b0;
    tick();
    chk(trig, 1'b0);
    samp(1);
    chk(trig, 1'b1);
    do_arm(3'h5);
    samp(3);
    chk(trig, 1'b0);
    run_block(1, 1'b0);
    // Complex pairs always covered
    run_block(2, 1'b1);
    repeat (3) begin
      run_block(1 + ($random(seed) & 3), 1'($random(seed)));
    end
    cplx = 1'b0;
    blen = 24'h1;
    ofs = 16'sh3;
    do_arm(`TRIG_SRC_IMM);
    samp(4);
    chk(24'(cnt), 24'h0);
    samp(1);
    chk(24'(cnt), 24'h1);
    ofs = -16'sh5;
    do_arm(`TRIG_SRC_IMM);
    samp(2);
    chk({pre, 8'(cnt)}, {16'h5, 8'h1});
    ofs = '0;
    cont = 1'b1;
    blen = 24'h2;
    do_arm(`TRIG_SRC_IMM);
    samp(5);
    chk(done, 1'b0);
    ovf = 1'b1;
    tick();
    ovf = 1'b0;
    tick();
    chk({done, ostop}, 2'b11);
    cont = 1'b0;
    fol = 1'b1;
    do_arm(3'h5);
    samp(1);
    chk(trig, 1'b0);
    fire = 1'b1;
    tick();
    fire = 1'b0;
    samp(2);
    chk(trig, 1'b1);
    // Let the partner release and the line resynchronise
    repeat (4) tick();
    drv = 1'b1;
    do_arm(`TRIG_SRC_IMM);
    samp(1);
    chk({sync_oe, trig}, 2'b10);
    i = 0;
    while (trig !== 1'b1 && i < 4) begin
      samp(1);
      i++;
    end
    chk({sync_oe, trig}, 2'b01);
    fol = 1'b0;
    do_arm(`TRIG_SRC_IMM);
    sen = 1'b1;
    r = 0;
    repeat (8) begin
      tick();
      sen = ~sen;
      r += int'(sync_oe === 1'b1);
    end
    sen = 1'b0;
    chk(24'(r), 24'h1);
    final_report();
  end
endmodule
`default_nettype wire
